// ==== design/rspc_reset_ctrl.sv ====
// reset sequencer with strap capture, fetch hold-off and clock echo pin
`timescale 1ns/1ns
// Summary of operation
// - after reset every peripheral line comes up as an input
// - clock echo pin carries the master clock during and after reset
// - echo pin becomes plain io only when io controller selects it
// - any reset restores peripheral defaults; fetch restarts at address zero
// - external reset is active low, asserts async, release synchronised
// - first fetch waits 80 master clock cycles after reset release
// - watchdog reset acts like external but keeps latched strap modes
// - external reset wins over a simultaneous watchdog reset
// - tri-state mode disables every output pin driver
// - tri-state mode routes external pins to the embedded flash
// - tri-state strap low in last ten cycles before release requests it
// - tri-state strap shares pin with gpio 21 and serial1 transmit
// - the four jtag pins are dedicated and never shared
// - boot-select strap in last ten cycles picks boot memory
module rspc_reset_ctrl #(
  parameter int unsigned FETCH_DLY = rspc_pkg::FETCH_DLY_CYC,
  parameter int unsigned STRAP_WIN = rspc_pkg::STRAP_WIN_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        ext_reset_n_i,
  input  wire logic        watchdog_unit_rst_i,
  input  wire logic        boot_select_strap_i,
  input  wire logic        tristate_strap_n_i,
  input  wire logic        echo_pin_is_gpio_i,
  input  wire logic        gpio_25_out_i,
  input  wire logic        gpio_25_oe_i,
  input  wire logic        gpio_line_21_out_i,
  input  wire logic        gpio_line_21_oe_i,
  input  wire logic        serial1_transmit_i,
  input  wire logic        serial1_transmit_oe_i,
  output logic             master_clock_echo_sel_o,
  output logic             echo_pin_out_o,
  output logic             echo_pin_oe_o,
  output logic             pin21_out_o,
  output logic             pin21_oe_o,
  output logic             periph_rst_o,
  output logic             core_rst_o,
  output logic             fetch_en_o,
  output logic [31:0]      fetch_addr_o,
  output logic             boot_select_o,
  output logic             tristate_mode_o,
  output logic             pad_drive_en_o,
  output logic             flash_pin_route_o
);
  typedef enum logic [1:0] {RSPC_IN_RESET, RSPC_HOLD, RSPC_RUN} rspc_state_t;

  default clocking rspc_cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // external level crosses in; the first stage is read only by the second
  logic       ext_s1_q, ext_s2_q, ext_prev_q;
  logic       wd_s1_q, wd_s2_q;
  logic       boot_s1_q, boot_s2_q, tri_s1_q, tri_s2_q;
  logic       ext_act, wd_act, ext_rise;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ext_s1_q   <= 1'b0;
      ext_s2_q   <= 1'b0;
      ext_prev_q <= 1'b0;
      wd_s1_q    <= 1'b0;
      wd_s2_q    <= 1'b0;
      boot_s1_q  <= 1'b0;
      boot_s2_q  <= 1'b0;
      tri_s1_q   <= 1'b1;
      tri_s2_q   <= 1'b1;
    end else begin
      ext_s1_q   <= ext_reset_n_i;
      ext_s2_q   <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
      wd_s1_q    <= watchdog_unit_rst_i;
      wd_s2_q    <= wd_s1_q;
      boot_s1_q  <= boot_select_strap_i;
      boot_s2_q  <= boot_s1_q;
      tri_s1_q   <= tristate_strap_n_i;
      tri_s2_q   <= tri_s1_q;
    end
  end

  // raw low pin asserts reset at once; release waits for the synchroniser
  assign ext_act  = !ext_reset_n_i || !ext_s2_q;
  assign wd_act   = wd_s2_q && !ext_act;
  assign ext_rise = ext_s2_q && !ext_prev_q;

  // strap window: last samples seen while reset is still low
  logic [STRAP_WIN-1:0] boot_hist_q, boot_hist_d, tri_hist_q, tri_hist_d;
  logic                 boot_q, boot_d, tri_q, tri_d;
  logic                 tri_req, boot_req;

  always_comb begin
    boot_hist_d = boot_hist_q;
    tri_hist_d  = tri_hist_q;
    boot_d      = boot_q;
    tri_d       = tri_q;
    // the pin is a strap only while the external reset is held
    if (!ext_s2_q) begin
      boot_hist_d = {boot_hist_q[STRAP_WIN-2:0], boot_s2_q};
      tri_hist_d  = {tri_hist_q[STRAP_WIN-2:0], tri_s2_q};
    end
    // a watchdog reset never reaches here, so the modes survive it
    if (ext_rise) begin
      boot_d = boot_req;
      tri_d  = tri_req;
    end
  end

  // request counts only if held for the whole window (majority not trusted)
  assign tri_req  = ~|tri_hist_q;
  assign boot_req = &boot_hist_q;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      boot_hist_q <= '0;
      tri_hist_q  <= '1;
      boot_q      <= rspc_pkg::BOOT_SEL_RST;
      tri_q       <= rspc_pkg::TRI_MODE_RST;
    end else begin
      boot_hist_q <= boot_hist_d;
      tri_hist_q  <= tri_hist_d;
      boot_q      <= boot_d;
      tri_q       <= tri_d;
    end
  end

  // fetch hold-off sequencer
  rspc_state_t                 st_q, st_d;
  logic [rspc_pkg::CNT_W-1:0]  cnt_q, cnt_d;
  // sync stages, the step out of in-reset and the inclusive last count all count
  localparam logic [rspc_pkg::CNT_W-1:0] CNT_LAST =
    rspc_pkg::CNT_W'(FETCH_DLY - 2 - rspc_pkg::SYNC_STAGES);

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    unique case (st_q)
      RSPC_IN_RESET: begin
        cnt_d = '0;
        if (!ext_act && !wd_act) st_d = RSPC_HOLD;
      end
      RSPC_HOLD: begin
        cnt_d = cnt_q + 1'b1;
        if (cnt_q == CNT_LAST) st_d = RSPC_RUN;
      end
      RSPC_RUN: ;
    endcase
    if (ext_act || wd_act) begin
      st_d  = RSPC_IN_RESET;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q  <= RSPC_IN_RESET;
      cnt_q <= '0;
    end else begin
      st_q  <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // registered pin and reset outputs
  logic run_d, drive_d;
  assign run_d   = (st_d == RSPC_RUN);
  assign drive_d = !tri_d;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      periph_rst_o            <= 1'b1;
      core_rst_o              <= 1'b1;
      fetch_en_o              <= 1'b0;
      fetch_addr_o            <= rspc_pkg::RESET_FETCH_ADDR;
      boot_select_o           <= rspc_pkg::BOOT_SEL_RST;
      tristate_mode_o         <= rspc_pkg::TRI_MODE_RST;
      pad_drive_en_o          <= 1'b0;
      flash_pin_route_o       <= 1'b0;
      master_clock_echo_sel_o <= 1'b1;
      echo_pin_out_o          <= 1'b0;
      echo_pin_oe_o           <= 1'b0;
      pin21_out_o             <= 1'b0;
      pin21_oe_o              <= 1'b0;
    end else begin
      periph_rst_o      <= !run_d;
      core_rst_o        <= !run_d;
      fetch_en_o        <= run_d;
      fetch_addr_o      <= rspc_pkg::RESET_FETCH_ADDR;
      boot_select_o     <= boot_d;
      tristate_mode_o   <= tri_d;
      pad_drive_en_o    <= drive_d;
      flash_pin_route_o <= tri_d;
      // echo pin: clock image unless io controller claims it after reset
      master_clock_echo_sel_o <= !(run_d && echo_pin_is_gpio_i);
      echo_pin_out_o    <= gpio_25_out_i;
      echo_pin_oe_o     <= drive_d && (!(run_d && echo_pin_is_gpio_i)
                           || (gpio_25_oe_i && run_d));
      // reset leaves peripheral lines as inputs
      pin21_out_o       <= serial1_transmit_oe_i ? serial1_transmit_i
                                                 : gpio_line_21_out_i;
      pin21_oe_o        <= drive_d && run_d && (serial1_transmit_oe_i ||
                           gpio_line_21_oe_i);
    end
  end

  // jtag pins never pass through this block, so none are muxed here

  a_fetch_gap: assert property ($rose(fetch_en_o) |->
    $past(st_q == RSPC_HOLD))
    else $error("fetch enabled without hold-off");
  a_rst_wins: assert property ((ext_act || wd_act) |=>
    !fetch_en_o && core_rst_o)
    else $error("reset did not stop fetch");
  a_ext_async: assert property (!ext_reset_n_i |=>
    core_rst_o)
    else $error("pin reset not applied");
  a_wd_keeps: assert property ((wd_s2_q && ext_s2_q &&
    ext_prev_q) |=> $stable(tristate_mode_o))
    else $error("watchdog changed strap mode");
  a_tri_nodrive: assert property (tristate_mode_o |->
    !pad_drive_en_o && !pin21_oe_o && flash_pin_route_o)
    else $error("pad driven in tri-state mode");
  a_io_inputs: assert property (core_rst_o |->
    !pin21_oe_o)
    else $error("peripheral line driven in reset");
  a_echo_clk: assert property (core_rst_o |->
    master_clock_echo_sel_o)
    else $error("clock echo lost during reset");
  a_strap_hold: assert property (!ext_rise |=>
    $stable(boot_select_o))
    else $error("boot select changed outside release");
  a_fetch_zero: assert property (fetch_en_o |->
    fetch_addr_o == rspc_pkg::RESET_FETCH_ADDR)
    else $error("fetch address not zero");

  c_run: cover property (@(posedge clk_i) $rose(fetch_en_o));
  c_tri: cover property (@(posedge clk_i) $rose(tristate_mode_o));
  c_wd: cover property (@(posedge clk_i) wd_act ##1 core_rst_o);
  c_both: cover property (@(posedge clk_i) wd_s2_q && !ext_reset_n_i);
endmodule // rspc_reset_ctrl

// ==== design/rspc_pkg.sv ====
// constants for the reset and strap sampling controller
package rspc_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 40;
  // strap window length in master clock cycles before release
  localparam int unsigned STRAP_WIN_CYC  = 10;
  // first fetch delay after release, in master clock cycles
  localparam int unsigned FETCH_DLY_CYC  = 80;
  localparam int unsigned SYNC_STAGES    = 2;
  localparam logic [31:0] RESET_FETCH_ADDR = 32'h0000_0000;
  localparam logic        BOOT_SEL_RST   = 1'b0;
  localparam logic        TRI_MODE_RST   = 1'b0;
  localparam int unsigned CNT_W          = 7;
endpackage

// ==== sim/rspc_board_model.sv ====
// board model driving the external reset pin and the two strap pins
`timescale 1ns/1ns
module rspc_board_model (
  input  wire logic clk_i,
  input  wire logic hold_i,
  input  wire logic tri_req_i,
  input  wire logic boot_req_i,
  input  wire logic glitch_i,
  output logic      ext_reset_n_o,
  output logic      boot_select_strap_o,
  output logic      tristate_strap_n_o
);
  logic [4:0] cnt_q = 5'h00;
  initial begin
    ext_reset_n_o       = 1'b0;
    boot_select_strap_o = 1'b0;
    tristate_strap_n_o  = 1'b1;
  end
  // reset is held at least ten running clocks before release
  always @(posedge clk_i) begin
    cnt_q <= (cnt_q == 5'h1f) ? cnt_q : cnt_q + 5'h01;
    if (!ext_reset_n_o && (hold_i || cnt_q < 5'h0a)) begin
      // tri strap stays high unless a request is made or glitch_i flips it
      tristate_strap_n_o  <= ~tri_req_i ^ glitch_i;
      boot_select_strap_o <= boot_req_i ^ glitch_i;
    end else if (!ext_reset_n_o) begin
      ext_reset_n_o <= 1'b1;
      cnt_q         <= 5'h00;
    end else if (hold_i) begin
      ext_reset_n_o <= 1'b0;
      cnt_q         <= 5'h00;
    end else if (cnt_q >= 5'h04) begin
      // out of reset the pins carry traffic that the straps must ignore
      tristate_strap_n_o  <= ~tri_req_i;
      boot_select_strap_o <= boot_req_i;
    end
  end
endmodule // rspc_board_model

// ==== sim/tb.sv ====
// self-checking bench for the reset and strap sampling controller
`timescale 1ns/1ns
module tb;
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, wd = 1'b0, gp = 1'b0;
  logic        hold = 1'b1, tr = 1'b0, bt = 1'b0, gl = 1'b0;
  logic        et = 1'b0, eb = 1'b0;
  logic [5:0]  rin = 6'h00;
  logic        ext_n, bstrap, tstrap_n, esel, eout, eoe, p21o, p21oe;
  logic        prst, crst, fen, bsel, tmode, pden, froute;
  logic [31:0] faddr;
  int          n_mismatch = 0, checks_done = 0;
  always #20 clk_i = ~clk_i;
  rspc_board_model board (.clk_i(clk_i), .hold_i(hold), .tri_req_i(tr),
    .boot_req_i(bt), .glitch_i(gl), .ext_reset_n_o(ext_n),
    .boot_select_strap_o(bstrap), .tristate_strap_n_o(tstrap_n));
  rspc_reset_ctrl dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .ext_reset_n_i(ext_n), .watchdog_unit_rst_i(wd),
    .boot_select_strap_i(bstrap), .tristate_strap_n_i(tstrap_n),
    .echo_pin_is_gpio_i(gp), .gpio_25_out_i(rin[0]), .gpio_25_oe_i(rin[1]),
    .gpio_line_21_out_i(rin[2]), .gpio_line_21_oe_i(rin[3]),
    .serial1_transmit_i(rin[4]), .serial1_transmit_oe_i(rin[5]),
    .master_clock_echo_sel_o(esel), .echo_pin_out_o(eout),
    .echo_pin_oe_o(eoe), .pin21_out_o(p21o), .pin21_oe_o(p21oe),
    .periph_rst_o(prst), .core_rst_o(crst), .fetch_en_o(fen),
    .fetch_addr_o(faddr), .boot_select_o(bsel), .tristate_mode_o(tmode),
    .pad_drive_en_o(pden), .flash_pin_route_o(froute));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wait_fen();
    for (int k = 0; k < 60 && fen !== 1'b1; k++) @(posedge clk_i);
    #1;
    chk(fen, 1'b1);
  endtask
  task automatic ext_cycle(input logic t, input logic b, input logic g,
                           input logic w, input int n);
    @(posedge clk_i);
    hold <= 1'b1;
    tr   <= t;
    bt   <= b;
    wd   <= w;
    for (int k = 1; k < n; k++) begin
      @(posedge clk_i);
      rin <= 6'($urandom);
      if (k == 4) wd <= 1'b0;
    end
    #1;
    chk(crst, 1'b1);
    chk(fen, 1'b0);
    chk(esel, 1'b1);
    chk(p21oe, 1'b0);
    if (g) begin
      @(posedge clk_i);
      gl <= 1'b1;
      @(posedge clk_i);
      gl <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
    // the board releases its pin one edge after hold drops
    @(posedge clk_i);
    hold <= 1'b0;
    rin  <= 6'h00;
    et = t & ~g;
    eb = b & ~g;
    repeat (80) @(posedge clk_i);
    #1;
    chk(fen, 1'b0);
    chk(crst, 1'b1);
    @(posedge clk_i);
    #1;
    chk(fen, 1'b1);
    chk(crst, 1'b0);
    chk(prst, 1'b0);
    chk(faddr, 32'h0000_0000);
    chk(tmode, et);
    chk(bsel, eb);
    chk(pden, !et);
    chk(froute, et);
    chk(p21oe, 1'b0);
    chk(eoe, !et);
    chk(esel, 1'b1);
    if (!et) begin
      @(posedge clk_i);
      gp  <= 1'b1;
      rin <= 6'h27;
      repeat (3) @(posedge clk_i);
      #1;
      chk(esel, 1'b0);
      chk(eout, 1'b1);
      chk(eoe, 1'b1);
      chk(p21oe, 1'b1);
      chk(p21o, 1'b0);
      @(posedge clk_i);
      gp  <= 1'b0;
      rin <= 6'h00;
      repeat (3) @(posedge clk_i);
      #1;
      chk(esel, 1'b1);
    end
  endtask
  initial begin
    void'($urandom(44930));
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    ext_cycle(1'b1, 1'b0, 1'b0, 1'b0, 20);
    ext_cycle(1'b1, 1'b1, 1'b1, 1'b0, 15);
    ext_cycle(1'b1, 1'b1, 1'b0, 1'b1, 25);
    for (int i = 0; i < 6; i++)
      ext_cycle(1'($urandom), 1'($urandom), 1'b0, 1'b0, 12 + $urandom % 20);
    ext_cycle(1'b0, 1'b1, 1'b0, 1'b0, 12);
    // watchdog with straps flipped at the pins: latched modes must survive
    @(posedge clk_i);
    tr <= !et;
    bt <= !eb;
    wd <= 1'b1;
    repeat (4) @(posedge clk_i);
    wd <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk(crst, 1'b1);
    chk(prst, 1'b1);
    chk(fen, 1'b0);
    repeat (60) @(posedge clk_i);
    #1;
    chk(fen, 1'b0);
    wait_fen();
    chk(tmode, et);
    chk(bsel, eb);
    complete_run();
  end
  initial begin
    repeat (6000) @(posedge clk_i);
    n_mismatch++;
    complete_run();
  end
endmodule // tb
